/* File: rtl/core_timing_pkg.sv */
// Shared constants for the flags, condition and cycle timing block.
// Assumes a single 40 MHz system clock and byte-addressed I/O space.
package core_timing_pkg;
    // I/O register byte addresses
    localparam logic [23:0] ADDR_PC_LIMIT  = 24'hffe004;
    localparam logic [23:0] ADDR_SP_LIMIT  = 24'hffe00c;
    localparam logic [23:0] ADDR_FLAGS     = 24'hffe010;
    localparam logic [23:0] ADDR_CORE_CTL  = 24'hffe012;
    // Reset values
    localparam logic [31:0] PC_LIMIT_RST   = 32'hffffffff;
    localparam logic [31:0] SP_LIMIT_RST   = 32'h00000000;
    localparam logic [7:0]  FLAGS_RST      = 8'h00;
    localparam logic [7:0]  CORE_CTL_RST   = 8'hff;
    localparam logic [7:0]  CORE_CTL_WMASK = 8'h03;
    localparam logic [31:0] UNMAPPED_READ  = 32'hffffffff;
    // Flag bit positions inside the flags byte
    localparam int FLAG_C     = 7;
    localparam int FLAG_Z     = 6;
    localparam int FLAG_S     = 5;
    localparam int FLAG_V     = 4;
    localparam int FLAG_B     = 3;
    localparam int FLAG_USER  = 2;
    localparam int FLAG_CHAINED_IRQ_ENABLE = 1;
    localparam int FLAG_GLOBAL_IRQ_ENABLE  = 0;
    // Data sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_QUAD = 2'h2;
    // Flag generation kinds
    localparam logic [2:0] FOP_NONE  = 3'h0;
    localparam logic [2:0] FOP_ADD   = 3'h1;
    localparam logic [2:0] FOP_SUB   = 3'h2;
    localparam logic [2:0] FOP_LOGIC = 3'h3;
    localparam logic [2:0] FOP_SHIFT = 3'h4;
    localparam logic [2:0] FOP_BLANK = 3'h5;
    // Instruction timing classes
    localparam logic [3:0] CLS_SIMPLE   = 4'h0;
    localparam logic [3:0] CLS_MEM_LOAD = 4'h1;
    localparam logic [3:0] CLS_MEM_SRC  = 4'h2;
    localparam logic [3:0] CLS_MEM_DST  = 4'h3;
    localparam logic [3:0] CLS_MUL      = 4'h4;
    localparam logic [3:0] CLS_SIGNED_DIVIDE_OP     = 4'h5;
    localparam logic [3:0] CLS_UNSIGNED_DIVIDE_OP     = 4'h6;
    localparam logic [3:0] CLS_WIDE_UNSIGNED_DIVIDE_OP   = 4'h7;
    localparam logic [3:0] CLS_SHIFT    = 4'h8;
    localparam logic [3:0] CLS_XSHIFT   = 4'h9;
    localparam logic [3:0] CLS_JUMP     = 4'ha;
    localparam logic [3:0] CLS_TRAP     = 4'hb;
    localparam logic [3:0] CLS_LINK     = 4'hc;
    localparam logic [3:0] CLS_UNLINK   = 4'hd;
    // Cycle figures
    localparam logic [9:0] CYC_MIN      = 10'h001;
    localparam logic [9:0] CYC_MUL_S    = 10'h00a;
    localparam logic [9:0] CYC_MUL_L    = 10'h012;
    localparam logic [9:0] CYC_DIV_S    = 10'h011;
    localparam logic [9:0] CYC_DIV_L    = 10'h021;
    localparam logic [9:0] CYC_DIV64    = 10'h022;
    localparam logic [9:0] CYC_LINK     = 10'h002;
    localparam logic [9:0] VEC_ACCESSES = 10'h004;
    localparam logic [9:0] STK_TRAP     = 10'h006;
    localparam logic [9:0] STK_FRAME    = 10'h004;
    localparam logic [31:0] SMALL_LIMIT = 32'h00010000;
    localparam logic [4:0] SHIFT_GROUP  = 5'h08;
endpackage

/* File: rtl/core_flags_timing.sv */
// Flags generation, branch condition test and execution cycle timing.
// Assumes the fetch unit reports when the next instruction is fetched.
// How it works
// - Simple register or immediate ops take one cycle
// - Multiply takes 10 small, 18 otherwise
// - Signed divide 17/18 small, 33/34 large
// - Unsigned divide 17 or 33; wide 34
// - Shift count/8 plus count%8; extended count+1
// - Jumps, calls and prefixes take zero cycles
// - Trap: 1 + 4 vector + 6 stack times
// - Link 2+4 stack times; unlink 1+4
// - Bus time is (waits+1) times ceiling ratio
// - Load then indirect base use adds one cycle
// - Stall until the next instruction is fetched
// - Entry pushes flags; return reloads stacked flags
// - Flags sized by destination, full for registers
// - Carry is carry or borrow at msb
// - Zero set when sized result is zero
// - Sign copies the sized result msb
// - Overflow from add, subtract, shift; logic clears
// - Blank set when tested operand was zero
// - User bit only written explicitly, reset zero
// - Entry copies old global enable to chained enable
// - Codes 0-7 test blank, lt, le, ule, v, s, z, c
// - Codes 8-15 invert codes 0-7
// - Global enable gates maskable interrupts, writable
`timescale 1ns/100ps
module core_flags_timing
    import core_timing_pkg::*;
#(
    parameter int WAIT_W = 4
)(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // I/O register port
    input  wire logic [23:0]       io_addr,
    input  wire logic              io_wr_en,
    input  wire logic [31:0]       io_wdata,
    output logic      [31:0]       io_rdata_reg,
    // Instruction issue
    input  wire logic              op_valid,
    input  wire logic [3:0]        op_class,
    input  wire logic [31:0]       opnd_dst,
    input  wire logic [31:0]       opnd_src,
    input  wire logic              div_negative,
    input  wire logic [4:0]        shift_count,
    input  wire logic              op_writes_base,
    input  wire logic [3:0]        op_dst_reg,
    input  wire logic              op_uses_base,
    input  wire logic [3:0]        op_base_reg,
    output logic                   op_ready_reg,
    output logic                   exec_done_reg,
    output logic      [9:0]        exec_cycles_reg,
    // Bus timing inputs
    input  wire logic [WAIT_W-1:0] data_waits,
    input  wire logic [1:0]        data_size,
    input  wire logic              data_bus_wide,
    input  wire logic [WAIT_W-1:0] vec_waits,
    input  wire logic              vec_bus_wide,
    input  wire logic [WAIT_W-1:0] stk_waits,
    input  wire logic              stk_bus_wide,
    // Fetch unit status
    input  wire logic              next_fetch_done,
    // Flag generation
    input  wire logic              flag_en,
    input  wire logic [2:0]        flag_op,
    input  wire logic              dst_is_mem,
    input  wire logic [31:0]       alu_result,
    input  wire logic              shift_carry,
    input  wire logic              shift_prev_msb,
    input  wire logic [31:0]       blank_operand,
    input  wire logic              flag_wr_en,
    input  wire logic [7:0]        flag_wr_mask,
    input  wire logic [7:0]        flag_wr_val,
    // Interrupt entry and return
    input  wire logic              entry_event,
    input  wire logic              interrupt_return_op_event,
    input  wire logic [7:0]        interrupt_return_op_flags,
    output logic      [7:0]        flags_push_reg,
    output logic                   irq_enable_reg,
    // Branch condition
    input  wire logic [3:0]        branch_condition_field,
    output logic                   branch_taken_reg,
    // Flags and control state
    output logic      [7:0]        flags_reg,
    output logic      [31:0]       pc_limit_reg,
    output logic      [31:0]       sp_limit_reg,
    output logic      [1:0]        dma_bw_reg
);

    // Execution sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_FETCH = 3'b100
    } exec_state_t;

    // Memory bus time: (waits+1) * ceil(bytes/bus bytes)
    function automatic logic [9:0] bus_time(input logic [WAIT_W-1:0] w,
                                            input logic [1:0] sz,
                                            input logic wide);
        logic [9:0] per;
        logic [9:0] n;
        per = 10'(w) + CYC_MIN;
        case (sz)
            SIZE_BYTE: n = 10'h001;
            SIZE_WORD: n = wide ? 10'h001 : 10'h002;
            default:   n = wide ? 10'h002 : 10'h004;
        endcase
        return 10'(per * n);
    endfunction

    // Mask of the active data size
    function automatic logic [31:0] size_mask(input logic [1:0] sz);
        case (sz)
            SIZE_BYTE: return 32'h000000ff;
            SIZE_WORD: return 32'h0000ffff;
            default:   return 32'hffffffff;
        endcase
    endfunction

    // Most significant bit at the active data size
    function automatic logic size_msb(input logic [31:0] v, input logic [1:0] sz);
        case (sz)
            SIZE_BYTE: return v[7];
            SIZE_WORD: return v[15];
            default:   return v[31];
        endcase
    endfunction

    // State registers
    exec_state_t state_reg;
    exec_state_t state_next;
    logic [9:0]  count_reg;        // Cycles left in RUN
    logic [9:0]  count_next;
    logic        base_pend_reg;    // Previous op loaded a base register
    logic [3:0]  base_idx_reg;     // Which register it loaded

    // Cycle cost decode
    wire logic       accept    = op_valid && (state_reg == ST_IDLE);
    wire logic       small_mul = (opnd_dst < SMALL_LIMIT) && (opnd_src < SMALL_LIMIT);
    wire logic       small_div = opnd_dst < SMALL_LIMIT;
    wire logic [9:0] data_bt   = bus_time(data_waits, data_size, data_bus_wide);
    wire logic [9:0] vec_bt    = bus_time(vec_waits, SIZE_QUAD, vec_bus_wide);
    wire logic [9:0] stk_bt    = bus_time(stk_waits, SIZE_QUAD, stk_bus_wide);
    wire logic [9:0] div_base  = small_div ? CYC_DIV_S : CYC_DIV_L;
    wire logic [9:0] shift_cyc = 10'(shift_count / SHIFT_GROUP)
                               + 10'(shift_count % SHIFT_GROUP);
    wire logic       hazard    = base_pend_reg && op_uses_base
                              && (op_base_reg == base_idx_reg);
    logic [9:0] base_cycles;

    // Minimum cycle count per class
    always_comb
    begin
        case (op_class)
            CLS_SIMPLE:   base_cycles = CYC_MIN;
            CLS_MEM_LOAD: base_cycles = data_bt;
            CLS_MEM_SRC:  base_cycles = 10'(CYC_MIN + data_bt);
            CLS_MEM_DST:  base_cycles = 10'(data_bt + data_bt);
            CLS_MUL:      base_cycles = small_mul ? CYC_MUL_S : CYC_MUL_L;
            CLS_SIGNED_DIVIDE_OP:     base_cycles = 10'(div_base + 10'(div_negative));
            CLS_UNSIGNED_DIVIDE_OP:     base_cycles = div_base;
            CLS_WIDE_UNSIGNED_DIVIDE_OP:   base_cycles = CYC_DIV64;
            CLS_SHIFT:    base_cycles = shift_cyc;
            CLS_XSHIFT:   base_cycles = 10'(10'(shift_count) + CYC_MIN);
            CLS_JUMP:     base_cycles = 10'h000;
            CLS_TRAP:     base_cycles = 10'(CYC_MIN + VEC_ACCESSES * vec_bt
                                         + STK_TRAP * stk_bt);
            CLS_LINK:     base_cycles = 10'(CYC_LINK + STK_FRAME * stk_bt);
            CLS_UNLINK:   base_cycles = 10'(CYC_MIN + STK_FRAME * stk_bt);
            default:      base_cycles = CYC_MIN;
        endcase
    end

    // Load-use delay adds one cycle
    wire logic [9:0] op_cycles = 10'(base_cycles + 10'(hazard));

    // Sequencer next state
    always_comb
    begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (accept)
                begin
                    count_next = op_cycles;
                    state_next = (op_cycles == 10'h000) ? ST_FETCH : ST_RUN;
                end
            end
            ST_RUN:
            begin
                count_next = count_reg - 10'h001;
                if (count_reg == 10'h001)
                    state_next = ST_FETCH;
            end
            ST_FETCH:
            begin
                // Hold until the following instruction is in
                if (next_fetch_done)
                    state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
                count_next = 10'h000;
            end
        endcase
    end

    wire logic finish = (state_reg == ST_FETCH) && next_fetch_done;

    // Sequencer registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg       <= ST_IDLE;
            count_reg       <= 10'h000;
            op_ready_reg    <= 1'b1;
            exec_done_reg   <= 1'b0;
            exec_cycles_reg <= 10'h000;
        end
        else
        begin
            state_reg     <= state_next;
            count_reg     <= count_next;
            op_ready_reg  <= (state_next == ST_IDLE);
            exec_done_reg <= finish;
            if (accept)
                exec_cycles_reg <= op_cycles;
        end
    end

    // Remember the last register loaded as a possible base
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            base_pend_reg <= 1'b0;
            base_idx_reg  <= 4'h0;
        end
        else if (accept)
        begin
            base_pend_reg <= op_writes_base;
            base_idx_reg  <= op_dst_reg;
        end
    end

    // Flag generation datapath
    wire logic [1:0]  fsize   = dst_is_mem ? data_size : SIZE_QUAD;
    wire logic [31:0] fmask   = size_mask(fsize);
    wire logic [31:0] am      = opnd_dst & fmask;
    wire logic [31:0] bm      = opnd_src & fmask;
    wire logic [32:0] add_wide = {1'b0, am} + {1'b0, bm};
    wire logic [31:0] res     = (flag_op == FOP_ADD) ? add_wide[31:0]
                              : (flag_op == FOP_SUB) ? (am - bm) : alu_result;
    wire logic        res_msb = size_msb(res, fsize);
    wire logic        res_zero = (res & fmask) == 32'h00000000;
    wire logic        sa      = size_msb(am, fsize);
    wire logic        sb      = size_msb(bm, fsize);
    wire logic        add_c   = add_wide > {1'b0, fmask};
    wire logic        sub_c   = am < bm;
    wire logic        add_v   = (sa == sb) && (res_msb != sa);
    wire logic        sub_v   = (sa != sb) && (res_msb == sb);
    wire logic        blank   = blank_operand == 32'h00000000;
    logic [7:0] alu_flags;

    // Arithmetic flag update per operation kind
    always_comb
    begin
        alu_flags = flags_reg;
        case (flag_op)
            FOP_ADD, FOP_SUB:
            begin
                alu_flags[FLAG_C] = (flag_op == FOP_ADD) ? add_c : sub_c;
                alu_flags[FLAG_V] = (flag_op == FOP_ADD) ? add_v : sub_v;
                alu_flags[FLAG_Z] = res_zero;
                alu_flags[FLAG_S] = res_msb;
                alu_flags[FLAG_B] = blank;
            end
            FOP_LOGIC:
            begin
                alu_flags[FLAG_V] = 1'b0;
                alu_flags[FLAG_Z] = res_zero;
                alu_flags[FLAG_S] = res_msb;
                alu_flags[FLAG_B] = blank;
            end
            FOP_SHIFT:
            begin
                alu_flags[FLAG_C] = shift_carry;
                alu_flags[FLAG_V] = shift_prev_msb != res_msb;
                alu_flags[FLAG_Z] = res_zero;
                alu_flags[FLAG_S] = res_msb;
            end
            FOP_BLANK: alu_flags[FLAG_B] = blank;
            default:   alu_flags = flags_reg;
        endcase
    end

    // Register port decode
    wire logic hit_pc    = io_addr == ADDR_PC_LIMIT;
    wire logic hit_sp    = io_addr == ADDR_SP_LIMIT;
    wire logic hit_flags = io_addr == ADDR_FLAGS;
    wire logic hit_ctl   = io_addr == ADDR_CORE_CTL;
    wire logic sw_flags  = io_wr_en && hit_flags;
    wire logic [7:0] ins_flags = (flags_reg & ~flag_wr_mask)
                               | (flag_wr_val & flag_wr_mask);

    // Flags byte: entry, return, writes, then ALU
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            flags_reg      <= FLAGS_RST;
            flags_push_reg <= FLAGS_RST;
        end
        else if (entry_event)
        begin
            flags_push_reg        <= flags_reg;
            flags_reg[FLAG_CHAINED_IRQ_ENABLE] <= flags_reg[FLAG_GLOBAL_IRQ_ENABLE];
        end
        else if (interrupt_return_op_event)
            flags_reg <= interrupt_return_op_flags;
        else if (sw_flags)
            flags_reg <= io_wdata[7:0];
        else if (flag_wr_en)
            flags_reg <= ins_flags;
        else if (flag_en)
            flags_reg <= alu_flags;
    end

    // Limit and control registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pc_limit_reg <= PC_LIMIT_RST;
            sp_limit_reg <= SP_LIMIT_RST;
            dma_bw_reg   <= CORE_CTL_RST[1:0];
        end
        else if (io_wr_en)
        begin
            if (hit_pc)
                pc_limit_reg <= io_wdata;
            if (hit_sp)
                sp_limit_reg <= io_wdata;
            if (hit_ctl)
                dma_bw_reg <= io_wdata[1:0];
        end
    end

    // Read data mux, unmapped reads as all ones
    wire logic [7:0]  ctl_view = (CORE_CTL_RST & ~CORE_CTL_WMASK) | {6'h00, dma_bw_reg};
    wire logic [31:0] rd_mux   = hit_pc    ? pc_limit_reg
                               : hit_sp    ? sp_limit_reg
                               : hit_flags ? {24'h000000, flags_reg}
                               : hit_ctl   ? {24'h000000, ctl_view}
                               : UNMAPPED_READ;

    // Branch condition evaluation
    wire logic sxv   = flags_reg[FLAG_S] ^ flags_reg[FLAG_V];
    logic      cond_base;
    always_comb
    begin
        case (branch_condition_field[2:0])
            3'h0:    cond_base = flags_reg[FLAG_B];
            3'h1:    cond_base = sxv;
            3'h2:    cond_base = flags_reg[FLAG_Z] | sxv;
            3'h3:    cond_base = flags_reg[FLAG_C] | flags_reg[FLAG_Z];
            3'h4:    cond_base = flags_reg[FLAG_V];
            3'h5:    cond_base = flags_reg[FLAG_S];
            3'h6:    cond_base = flags_reg[FLAG_Z];
            default: cond_base = flags_reg[FLAG_C];
        endcase
    end
    wire logic cond_true = cond_base ^ branch_condition_field[3];

    // Registered status outputs
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            io_rdata_reg     <= UNMAPPED_READ;
            branch_taken_reg <= 1'b0;
            irq_enable_reg   <= 1'b0;
        end
        else
        begin
            io_rdata_reg     <= rd_mux;
            branch_taken_reg <= cond_true;
            irq_enable_reg   <= flags_reg[FLAG_GLOBAL_IRQ_ENABLE];
        end
    end

    // Cycles spent in RUN, checked against the issued cost
    logic [9:0] run_seen_reg;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            run_seen_reg <= 10'h000;
        else if (accept)
            run_seen_reg <= 10'h000;
        else if (state_reg == ST_RUN)
            run_seen_reg <= run_seen_reg + 10'h001;
    end

    AST_RUN_LENGTH: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == ST_RUN) && (state_next == ST_FETCH)
        |-> (run_seen_reg + 10'h001 == exec_cycles_reg))
        else $error("run length differs from issued cycle count");

    AST_MUL_COST: assert property (@(posedge clk_sys) disable iff (rst)
        accept && (op_class == CLS_MUL) && !hazard
        |=> (exec_cycles_reg == ($past(small_mul) ? 10'h00a : 10'h012)))
        else $error("multiply cycle count wrong");

    AST_SIGNED_DIVIDE_OP_COST: assert property (@(posedge clk_sys) disable iff (rst)
        accept && (op_class == CLS_SIGNED_DIVIDE_OP) && !hazard && small_div && div_negative
        |=> (exec_cycles_reg == 10'h012))
        else $error("signed divide negative small cost wrong");

    AST_JUMP_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
        accept && (op_class == CLS_JUMP) && !hazard
        |=> (state_reg == ST_FETCH))
        else $error("jump spent execution cycles");

    AST_FETCH_STALL: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == ST_FETCH) && !next_fetch_done |=> !exec_done_reg)
        else $error("finished before next fetch completed");

    AST_HAZARD_ADD: assert property (@(posedge clk_sys) disable iff (rst)
        accept && hazard |=> (exec_cycles_reg == $past(base_cycles) + 10'h001))
        else $error("load-use delay cycle missing");

    AST_CHAIN_COPY: assert property (@(posedge clk_sys) disable iff (rst)
        entry_event |=> (flags_reg[FLAG_CHAINED_IRQ_ENABLE] == $past(flags_reg[FLAG_GLOBAL_IRQ_ENABLE]))
                        && (flags_push_reg == $past(flags_reg)))
        else $error("entry did not push flags or copy enable");

    AST_INTERRUPT_RETURN_OP_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
        interrupt_return_op_event && !entry_event |=> (flags_reg == $past(interrupt_return_op_flags)))
        else $error("return did not reload flags");

    AST_USER_KEEP: assert property (@(posedge clk_sys) disable iff (rst)
        flag_en && !flag_wr_en && !sw_flags && !entry_event && !interrupt_return_op_event
        |=> $stable(flags_reg[FLAG_USER]))
        else $error("user bit changed by arithmetic");

    AST_COND_INVERT: assert property (@(posedge clk_sys) disable iff (rst)
        (branch_condition_field[2:0] == 3'h6)
        |=> (branch_taken_reg == ($past(flags_reg[FLAG_Z]) ^ $past(branch_condition_field[3]))))
        else $error("branch condition sense wrong");

endmodule

/* File: tb/fetch_model.sv */
// Fetch unit model: reports when the next instruction is fully fetched.
// Assumes the bench sets the fetch lag, in cycles, before each issue.
`timescale 1ns/100ps
module fetch_model (
    // Clock, reset and issue
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       issue,
    input  wire logic [7:0] lag,
    // Fetch status
    output logic            next_fetch_done
);
    logic [7:0] left_reg; // Fetch cycles still to go
    // Restart the fetch on each issue, then count down
    always_ff @(posedge clk_sys or posedge rst)
        if (rst) left_reg <= 8'h00;
        else if (issue) left_reg <= lag;
        else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
    assign next_fetch_done = (left_reg == 8'h00);
endmodule

/* File: tb/testbench.sv */
// Testbench for the flags, condition and cycle timing block.
// Assumes inputs change at the falling edge and a fetch model beside it.
`timescale 1ns/100ps
module testbench import core_timing_pkg::*;;
    localparam logic [31:0] BIG = 32'h00010000; // First large operand
    logic clk_sys = 0, rst = 1, io_wr_en, op_valid, div_negative, op_writes_base, op_uses_base;
    logic data_bus_wide, vec_bus_wide, stk_bus_wide, flag_en, dst_is_mem, shift_carry;
    logic shift_prev_msb, flag_wr_en, entry_event, interrupt_return_op_event, next_fetch_done, op_ready_reg;
    logic exec_done_reg, irq_enable_reg, branch_taken_reg;
    logic [31:0] io_wdata, opnd_dst, opnd_src, alu_result, blank_operand, io_rdata_reg;
    logic [31:0] pc_limit_reg, sp_limit_reg;
    logic [23:0] io_addr;
    logic [3:0] op_class, op_dst_reg, op_base_reg, data_waits, vec_waits, stk_waits;
    logic [3:0] branch_condition_field;
    logic [2:0] flag_op;
    logic [1:0] data_size, dma_bw_reg;
    logic [4:0] shift_count;
    logic [7:0] flag_wr_mask, flag_wr_val, interrupt_return_op_flags, flags_push_reg, flags_reg, lag;
    logic [9:0] exec_cycles_reg;
    int fail_count = 0, comparisons = 0, n, f, c;
    core_flags_timing uut (.*);
    fetch_model fetch (.clk_sys, .rst, .issue(op_valid & op_ready_reg), .lag, .next_fetch_done);
    always #12.5 clk_sys = ~clk_sys;
    // Compare seen against expected
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Register write, one cycle strobe
    task wr(input logic [23:0] a, input logic [31:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr_en = 1;
        @(negedge clk_sys) io_wr_en = 0;
    endtask
    // Register read, data one cycle after the address
    task rd(input logic [23:0] a, input logic [31:0] e);
        io_addr = a;
        @(negedge clk_sys) chk(io_rdata_reg, e);
    endtask
    // Issue one op and time it to the done pulse
    task op(input logic [3:0] k, input logic [31:0] d, input logic ng, input logic [4:0] s,
            input logic [9:0] e);
        op_class = k;
        opnd_dst = d;
        opnd_src = d;
        div_negative = ng;
        shift_count = s;
        op_valid = 1;
        @(negedge clk_sys) op_valid = 0;
        for (n = 0; n < 300 && exec_done_reg !== 1'b1; n++) @(negedge clk_sys);
        if (n == 300) fail_count++;
        if (n == 300) final_report;
        chk(op_ready_reg, 1);
        chk({22'h0, exec_cycles_reg}, {22'h0, e});
        if (lag == 8'h00) chk(n, e + 1);
        else chk(n >= lag, 1);
        @(negedge clk_sys);
    endtask
    // Expected jump decision for flags f and field c
    function logic br(input logic [7:0] f, input logic [3:0] c);
        logic [7:0] t;
        t = {f[7], f[6], f[5], f[4], f[7] | f[6], f[6] | (f[5] ^ f[4]), f[5] ^ f[4], f[3]};
        return t[c[2:0]] ^ c[3];
    endfunction
    // Main sequence
    initial
    begin
        {io_addr, io_wr_en, io_wdata, op_valid, op_class, opnd_dst, opnd_src, div_negative,
         shift_count, op_writes_base, op_dst_reg, op_uses_base, op_base_reg, data_size, flag_en,
         flag_op, dst_is_mem, alu_result, shift_carry, shift_prev_msb, blank_operand, flag_wr_en,
         flag_wr_mask, flag_wr_val, entry_event, interrupt_return_op_event, interrupt_return_op_flags, branch_condition_field,
         lag, stk_waits, stk_bus_wide} = '0;
        {data_waits, data_bus_wide, vec_waits, vec_bus_wide} = {4'h2, 1'b1, 4'h1, 1'b1};
        repeat (5) @(negedge clk_sys);
        rst = 0;
        rd(ADDR_PC_LIMIT, PC_LIMIT_RST);
        rd(ADDR_FLAGS, 0);
        rd(24'hffe008, UNMAPPED_READ);
        wr(ADDR_CORE_CTL, 0);
        rd(ADDR_CORE_CTL, 8'hfc);
        rd(ADDR_SP_LIMIT, SP_LIMIT_RST);
        wr(ADDR_SP_LIMIT, 32'h0000a5a4);
        rd(ADDR_SP_LIMIT, 32'h0000a5a4);
        chk(sp_limit_reg, 32'h0000a5a4);
        chk(pc_limit_reg, PC_LIMIT_RST);
        chk(dma_bw_reg, 2'h0);
        $display("register test done");
        op(CLS_SIMPLE, 5, 0, 0, 1);
        op(CLS_JUMP, 5, 0, 0, 0);
        op(CLS_MUL, BIG - 1, 0, 0, 10);
        op(CLS_MUL, BIG, 0, 0, 18);
        op(CLS_SIGNED_DIVIDE_OP, 5, 1, 0, 18);
        op(CLS_SIGNED_DIVIDE_OP, BIG, 0, 0, 33);
        op(CLS_SIGNED_DIVIDE_OP, BIG, 1, 0, 34);
        op(CLS_UNSIGNED_DIVIDE_OP, 5, 0, 0, 17);
        op(CLS_UNSIGNED_DIVIDE_OP, BIG, 0, 0, 33);
        op(CLS_WIDE_UNSIGNED_DIVIDE_OP, 5, 0, 0, 34);
        op(CLS_SHIFT, 5, 0, 13, 6);
        op(CLS_XSHIFT, 5, 0, 13, 14);
        op(CLS_TRAP, 5, 0, 0, 41);
        op(CLS_LINK, 5, 0, 0, 18);
        op(CLS_UNLINK, 5, 0, 0, 17);
        op(CLS_MEM_SRC, 5, 0, 0, 4);
        op(CLS_MEM_DST, 5, 0, 0, 6);
        {op_writes_base, op_dst_reg} = {1'b1, 4'h3};
        op(CLS_MEM_LOAD, 5, 0, 0, 3);
        {op_writes_base, op_uses_base, op_base_reg} = {1'b0, 1'b1, 4'h3};
        op(CLS_SIMPLE, 5, 0, 0, 2);
        op_uses_base = 0;
        lag = 8'd12;
        op(CLS_SIMPLE, 5, 0, 0, 1);
        lag = 0;
        $display("timing test done");
        for (f = 0; f < 2; f++)
        begin
            wr(ADDR_FLAGS, f ? 8'h90 : 8'h28);
            for (c = 0; c < 16; c++)
            begin
                branch_condition_field = c[3:0];
                @(negedge clk_sys) chk(branch_taken_reg, br(f ? 8'h90 : 8'h28, c[3:0]));
            end
        end
        $display("branch test done");
        wr(ADDR_FLAGS, 8'h04);
        {opnd_dst, opnd_src, flag_op, flag_en} = {32'hffffffff, 32'h1, FOP_ADD, 1'b1};
        @(negedge clk_sys) chk(flags_reg, 8'hcc);
        {opnd_dst, dst_is_mem} = {32'h7f, 1'b1};
        @(negedge clk_sys) chk(flags_reg[7:4], 4'h3);
        {opnd_dst, opnd_src, flag_op} = {32'h1, 32'h80, FOP_SUB};
        @(negedge clk_sys) chk(flags_reg[7:3], 5'h17);
        {alu_result, blank_operand, flag_op} = {32'h0, 32'h5, FOP_LOGIC};
        @(negedge clk_sys) chk(flags_reg[7:3], 5'h18);
        {alu_result, shift_prev_msb, flag_op} = {32'h40, 1'b1, FOP_SHIFT};
        @(negedge clk_sys) chk(flags_reg[7:2], 6'h05);
        {blank_operand, flag_op} = {32'h0, FOP_BLANK};
        @(negedge clk_sys) flag_en = 0;
        chk(flags_reg[7:3], 5'h03);
        wr(ADDR_FLAGS, 8'h01);
        entry_event = 1;
        @(negedge clk_sys) entry_event = 0;
        chk(flags_push_reg, 8'h01);
        chk(flags_reg[1], 1);
        @(negedge clk_sys) chk(irq_enable_reg, 1);
        {interrupt_return_op_flags, interrupt_return_op_event} = {8'h84, 1'b1};
        @(negedge clk_sys) interrupt_return_op_event = 0;
        chk(flags_reg, 8'h84);
        $display("flags test done");
        final_report;
    end
endmodule
